//--- logic/uart_fractional_baud_rx_fifo.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// [R1] Bit rate is clock over divisor plus fraction adjust eighths.
// [R2] A free-running 16-bit timer sets the bit period; the code restarts each timer per frame and stops the receive one when idle.
// [R3] Software keeps divisor at least 16 (range 0) or 8 (range 1).
// [R4] Software writes divisor low byte before the high byte.
// [R5] Range 0 samples at half, half plus one, half plus two.
// [R6] Range 1 samples at half minus one, half, half plus two.
// [R7] Fraction added each bit; a carry lengthens that bit by one clock.
// [R8] Fraction correction applies to transmit and receive timing.
// [R9] Software loads truncated ratio and rounded fraction times eight.
// [R10] Threshold code 00 means four bytes; 01..11 one to three.
// [R11] Reaching threshold sets data flag; interrupt if enabled.
// [R12] Fill count rises per byte stored, falls per byte read.
// [R13] Full buffer: fifth byte held, sixth replaces it, count stays 4.
// [R14] Fill count clears on reset and on setting unit enable.
// [R15] Fill count is bits 2..0, read only, upper bits zero.
// [R16] After reset buffer empty, control fields zero.
// [R17] Buffer control bits 7 and 6 read zero.
// [R18] Disable empties buffer, clears count and flags, keeps config.
// [R19] Receive interrupt enable gates data and overrun flags.
// [R20] Fraction accumulator clears at each frame start bit.
module uart_fractional_baud_rx_fifo (
   input wire logic aclk, // Clock, 200 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [7:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [7:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic rxd, // Serial receive pin.
   input wire logic tx_frame_start, // Transmitter frame start pulse.
   output logic tx_bit_tick, // Transmit bit boundary pulse.
   output logic uart_irq // Receive interrupt request.
);
   import uart_frac_pkg::*;
`include "uart_frac_defines.svh"

   bit_timing_if rx_tif ();
   bit_timing_if tx_tif ();

   byte_t divisor_low_byte, divisor_high_byte, div_low_stage;
   logic [2:0] fraction_adjust;
   logic divisor_range_select;
   logic [1:0] rx_fill_threshold;
   logic serial_unit_enable;
   logic rx_irq_enable;
   logic overrun_flag;
   logic rx_data_flag;
   logic [2:0] rx_fill_count;
   byte_t rx_mem [0:3];
   logic [1:0] wr_ptr;
   logic [1:0] rd_ptr;
   byte_t hold_byte;
   logic hold_valid;
   logic [2:0] rxs;
   logic rx_level;
   rx_state_e rx_state;
   logic [2:0] samp;
   logic [2:0] bit_idx;
   byte_t shift;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held, w_held, do_write, do_read, byte_done, pop, push;
   logic enable_rise, maj;

   // Two-of-three vote over the sampled levels of one bit.
   function automatic logic vote(input logic [2:0] s);
      vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = (a == `OFS_DIV_LOW) || (a == `OFS_DIV_HIGH) ||
         (a == `OFS_BUF_CTRL) || (a == `OFS_UNIT_CTRL) ||
         (a == `OFS_STATUS);
   endfunction

   // =====================================================
   // Bit timers, one per direction
   assign rx_tif.divisor = {divisor_high_byte, divisor_low_byte};
   assign rx_tif.frac = fraction_adjust;
   assign rx_tif.range_sel = divisor_range_select;
   assign tx_tif.divisor = {divisor_high_byte, divisor_low_byte};
   assign tx_tif.frac = fraction_adjust; // R8
   assign tx_tif.range_sel = divisor_range_select;
   assign tx_tif.restart = tx_frame_start && serial_unit_enable; // R20
   assign tx_tif.stop = !serial_unit_enable;
   assign tx_bit_tick = tx_tif.bit_end; // R8

   bit_timer u_rx_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tif(rx_tif.timer)
   );

   bit_timer u_tx_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tif(tx_tif.timer)
   );

   // =====================================================
   // Receive pin synchroniser and filter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxs <= 3'h7;
         rx_level <= 1'b1;
      end else begin
         rxs <= {rxs[1:0], rxd};
         if (rxs[1] == rxs[2]) begin
            rx_level <= rxs[2];
         end
      end
   end

   // =====================================================
   // Receive frame sequencer
   assign rx_tif.restart = serial_unit_enable && (rx_state == RX_IDLE)
      && !rx_level; // R20
   assign rx_tif.stop = !serial_unit_enable ||
      (rx_state == RX_IDLE && rx_level);
   assign maj = vote(samp);
   // The frame ends at the stop bit's last sample, so a new start
   // edge that follows at once is not missed.
   assign byte_done = (rx_state == RX_STOP) && rx_tif.sample[2]
      && vote({rx_level, samp[1:0]});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (rx_tif.sample[i]) begin
               samp[i] <= rx_level; // R5 R6
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_unit_enable) begin
         rx_state <= RX_IDLE;
         bit_idx <= 3'h0;
         shift <= `RST_BYTE;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (!rx_level) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rx_tif.bit_end) begin
                  rx_state <= maj ? RX_IDLE : RX_DATA;
                  bit_idx <= 3'h0;
               end
            end
            RX_DATA: begin
               if (rx_tif.bit_end) begin
                  shift <= {maj, shift[7:1]};
                  bit_idx <= bit_idx + 3'h1;
                  if (bit_idx == 3'h7) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_tif.sample[2]) begin
                  rx_state <= RX_IDLE;
               end
            end
            default: begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   // =====================================================
   // Four-byte receive buffer and fill counter
   assign pop = do_read && (s_axi_araddr == `OFS_RX_DATA) &&
      (rx_fill_count != 3'h0);
   assign push = (byte_done || hold_valid) && ((rx_fill_count < `RX_DEPTH)
      || pop);

   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_unit_enable || enable_rise) begin
         rx_fill_count <= 3'h0; // R14 R18 R16
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 2'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 2'h1;
         end
         if (push && !pop) begin
            rx_fill_count <= rx_fill_count + 3'h1; // R12
         end else if (pop && !push) begin
            rx_fill_count <= rx_fill_count - 3'h1; // R12
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (push) begin
         // A held byte is older than one just finishing, so it goes first.
         rx_mem[wr_ptr] <= hold_valid ? hold_byte : shift;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_unit_enable) begin
         hold_valid <= 1'b0; // R18
         hold_byte <= `RST_BYTE;
      end else if (byte_done && (hold_valid ||
         (rx_fill_count == `RX_DEPTH && !pop))) begin
         hold_valid <= 1'b1; // R13
         hold_byte <= shift; // R13
      end else if (push) begin
         hold_valid <= 1'b0;
      end
   end

   always_comb begin
      case (rx_fill_threshold)
         2'h0: rx_data_flag = (rx_fill_count >= `RX_DEPTH); // R10
         2'h1: rx_data_flag = (rx_fill_count >= 3'h1); // R10
         2'h2: rx_data_flag = (rx_fill_count >= 3'h2); // R10
         default: rx_data_flag = (rx_fill_count >= 3'h3); // R10
      endcase
   end

   assign uart_irq = rx_irq_enable && (rx_data_flag || overrun_flag); // R11 R19

   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_unit_enable) begin
         overrun_flag <= 1'b0; // R18
      end else if (byte_done && hold_valid) begin
         overrun_flag <= 1'b1; // R13
      end else if (do_write && aw_addr == `OFS_STATUS && w_strb[0] &&
         w_data[`ST_OVR_BIT]) begin
         overrun_flag <= 1'b0;
      end
   end

   // =====================================================
   // AXI4-Lite write channel
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit(aw_addr) ? `AXI_OKAY : `AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divisor_low_byte <= `RST_BYTE;
         divisor_high_byte <= `RST_BYTE;
         div_low_stage <= `RST_BYTE;
         fraction_adjust <= 3'h0; // R16
         divisor_range_select <= 1'b0; // R16
         rx_fill_threshold <= 2'h0; // R16
         serial_unit_enable <= 1'b0;
         rx_irq_enable <= 1'b0;
         enable_rise <= 1'b0;
      end else begin
         enable_rise <= 1'b0;
         if (do_write && w_strb[0]) begin
            case (aw_addr)
               // The low byte waits until the high byte arrives, so
               // the timer never runs on half a new divisor.
               `OFS_DIV_LOW: div_low_stage <= w_data[7:0]; // R4
               `OFS_DIV_HIGH: begin
                  divisor_high_byte <= w_data[7:0];
                  divisor_low_byte <= div_low_stage; // R4
               end
               `OFS_BUF_CTRL: begin
                  rx_fill_threshold <= w_data[`BC_THR_LSB +: 2];
                  divisor_range_select <= w_data[`BC_RANGE_BIT];
                  fraction_adjust <= w_data[`BC_FRAC_LSB +: 3];
               end
               `OFS_UNIT_CTRL: begin
                  serial_unit_enable <= w_data[`UC_ENABLE_BIT];
                  rx_irq_enable <= w_data[`UC_IRQ_EN_BIT];
                  enable_rise <= w_data[`UC_ENABLE_BIT]; // R14
               end
               default: begin
               end
            endcase
         end
      end
   end

   // =====================================================
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `AXI_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         case (s_axi_araddr)
            `OFS_DIV_LOW: s_axi_rdata[7:0] <= div_low_stage;
            `OFS_DIV_HIGH: s_axi_rdata[7:0] <= divisor_high_byte;
            `OFS_BUF_CTRL: s_axi_rdata[5:0] <= {fraction_adjust,
               divisor_range_select, rx_fill_threshold}; // R17
            `OFS_FILL_CNT: s_axi_rdata[2:0] <= rx_fill_count; // R15
            `OFS_UNIT_CTRL: s_axi_rdata[1:0] <= {rx_irq_enable,
               serial_unit_enable};
            `OFS_STATUS: s_axi_rdata[1:0] <= {overrun_flag, rx_data_flag};
            `OFS_RX_DATA: begin
               if (rx_fill_count != 3'h0) begin
                  s_axi_rdata[7:0] <= rx_mem[rd_ptr];
               end
            end
            default: s_axi_rresp <= `AXI_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // uart_fractional_baud_rx_fifo

//--- logic/uart_frac_defines.svh
`ifndef UART_FRAC_DEFINES_SVH
`define UART_FRAC_DEFINES_SVH
// =====================================================
// Register byte offsets
`define OFS_DIV_LOW 8'h00
`define OFS_DIV_HIGH 8'h04
`define OFS_BUF_CTRL 8'h08
`define OFS_FILL_CNT 8'h0C
`define OFS_UNIT_CTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_RX_DATA 8'h18
// =====================================================
// Field positions
`define BC_THR_LSB 0
`define BC_RANGE_BIT 2
`define BC_FRAC_LSB 3
`define UC_ENABLE_BIT 0
`define UC_IRQ_EN_BIT 1
`define ST_DATA_BIT 0
`define ST_OVR_BIT 1
// =====================================================
// Reset values and counts
`define RST_BYTE 8'h00
`define RX_DEPTH 3'h4
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

//--- logic/uart_frac_pkg.sv
package uart_frac_pkg;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
   typedef logic [7:0] byte_t;
endpackage

//--- logic/bit_timing_if.sv
`timescale 1ns/1ps
interface bit_timing_if;
   logic [15:0] divisor;
   logic [2:0] frac;
   logic range_sel;
   logic restart;
   logic stop;
   logic bit_end;
   logic [2:0] sample;
   modport timer (input divisor, frac, range_sel, restart, stop,
      output bit_end, sample);
   modport user (output divisor, frac, range_sel, restart, stop,
      input bit_end, sample);
endinterface

//--- logic/bit_timer.sv
`timescale 1ns/1ps
module bit_timer (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Synchronous reset, active low.
   bit_timing_if.timer tif // Timing request and strobes.
);
   logic [15:0] cnt, half, p0, p1, p2;
   logic [2:0] acc;
   logic extra, run;
   logic [3:0] next_sum;
   logic [16:0] end_at;

   assign next_sum = {1'b0, acc} + {1'b0, tif.frac};
   assign end_at = {1'b0, tif.divisor} + {16'h0000, extra} - 17'h00001;
   assign half = tif.divisor >> 1;
   // Range 1 moves the first two points one clock earlier for short bits.
   assign p0 = tif.range_sel ? half - 16'h0001 : half; // R5 R6
   assign p1 = tif.range_sel ? half : half + 16'h0001; // R5 R6
   assign p2 = half + 16'h0002; // R5 R6
   assign tif.bit_end = run && ({1'b0, cnt} == end_at);
   assign tif.sample[0] = run && (cnt == p0);
   assign tif.sample[1] = run && (cnt == p1);
   assign tif.sample[2] = run && (cnt == p2);

   // =====================================================
   // 16-bit bit-period counter, restarted per frame, cleared at each bit end
   always_ff @(posedge aclk) begin
      if (!aresetn || tif.stop) begin
         run <= 1'b0;
         cnt <= 16'h0000;
      end else if (tif.restart) begin
         run <= 1'b1;
         cnt <= 16'h0000; // R2
      end else if (tif.bit_end) begin
         cnt <= 16'h0000; // R1 R2
      end else if (run) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // =====================================================
   // Fraction accumulator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc <= 3'h0;
         extra <= 1'b0;
      end else if (tif.restart) begin
         // The first bit of a frame gets 0 + frac, never a carry.
         acc <= tif.frac; // R20
         extra <= 1'b0;
      end else if (tif.bit_end) begin
         acc <= next_sum[2:0]; // R7
         extra <= next_sum[3]; // R7 R1
      end
   end
endmodule // bit_timer

//--- dv/uart_frac_props.sv
`timescale 1ns/1ps
`include "uart_frac_defines.svh"
module uart_frac_props (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [7:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic [1:0] s_axi_bresp, // Write response.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [7:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic [31:0] s_axi_rdata, // Read data.
   input wire logic [1:0] s_axi_rresp, // Read response.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic tx_bit_tick, // Transmit bit boundary pulse.
   input wire logic uart_irq // Receive interrupt request.
);
   logic [7:0] last_ar;
   logic [7:0] last_aw;
   logic bad_ar;
   // ==========================================================
   // Addresses of the accesses now being answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_ar <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         last_ar <= s_axi_araddr;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_aw <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         last_aw <= s_axi_awaddr;
      end
   end
   assign bad_ar = (last_ar > `OFS_RX_DATA) || (last_ar[1:0] != 2'h0);
   // ==========================================================
   // Properties
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wr_lat_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after request");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_resp_a: assert property (s_axi_rvalid |->
      s_axi_rresp == (bad_ar ? `AXI_SLVERR : `AXI_OKAY))
      else $error("read response code wrong");
   ro_write_a: assert property (s_axi_bvalid && (last_aw == `OFS_FILL_CNT ||
      last_aw == `OFS_RX_DATA) |-> s_axi_bresp == `AXI_SLVERR)
      else $error("write to read-only place accepted");
   cnt_field_a: assert property (s_axi_rvalid && last_ar == `OFS_FILL_CNT |->
      s_axi_rdata[31:3] == 29'h0 && s_axi_rdata[2:0] <= `RX_DEPTH)
      else $error("fill count out of range");
   ctrl_field_a: assert property (s_axi_rvalid && last_ar == `OFS_BUF_CTRL |->
      s_axi_rdata[31:6] == 26'h0)
      else $error("buffer control upper bits set");
   cover property (s_axi_rvalid && s_axi_rresp == `AXI_SLVERR);
   cover property (uart_irq);
   cover property (tx_bit_tick);
endmodule // uart_frac_props

bind uart_fractional_baud_rx_fifo uart_frac_props u_props (.*);

//--- dv/uart_line_model.sv
`timescale 1ns/1ps
module uart_line_model (
   input wire logic aclk, // Clock shared with the block.
   output logic rxd // Serial line toward the block, idle high.
);
   initial rxd = 1'b1;
   // ==========================================================
   // One 8N1 frame, LSB first, stretched by the fraction carry
   task automatic send(input logic [7:0] b, input logic [15:0] dv,
      input logic [2:0] fr);
      logic [9:0] bits;
      logic [3:0] sum;
      logic [2:0] acc;
      int i;
      begin
         bits = {1'b1, b, 1'b0};
         acc = 3'h0;
         @(posedge aclk);
         for (i = 0; i < 10; i++) begin
            sum = {1'b0, acc} + {1'b0, fr};
            acc = sum[2:0];
            rxd <= bits[i];
            repeat (int'(dv) + int'(sum[3])) @(posedge aclk);
         end
         // The idle gap lets the receiver finish the stop bit.
         repeat (2 * int'(dv)) @(posedge aclk);
      end
   endtask
endmodule // uart_line_model

//--- dv/tb.sv
`timescale 1ns/1ps
`include "uart_frac_defines.svh"
module tb;
   import uart_frac_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, tx_frame_start;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tx_bit_tick, uart_irq, rxd;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_mismatch = 0;
   int total_checks = 0;
   always #2.5 aclk = ~aclk;
   uart_fractional_baud_rx_fifo dut (.*);
   uart_line_model line (.aclk(aclk), .rxd(rxd));
   // ==========================================================
   // Reporting and comparison
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic hang;
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report;
   endtask
   task automatic chk_word(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, e, input string m);
      chk_word({31'h0, g}, {31'h0, e}, m);
   endtask
   // ==========================================================
   // Register bus master
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 100) hang;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 100) hang;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk_word({30'h0, r}, {30'h0, `AXI_OKAY}, "write response");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input string m);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk_word({30'h0, r}, {30'h0, `AXI_OKAY}, "read response");
      chk_word(d, e, m);
   endtask
   task automatic setup(input logic [15:0] dv, input logic [2:0] fr,
      input logic rg, input logic [1:0] th);
      wr(`OFS_DIV_LOW, {24'h0, dv[7:0]});
      wr(`OFS_DIV_HIGH, {24'h0, dv[15:8]});
      wr(`OFS_BUF_CTRL, {26'h0, fr, rg, th});
   endtask
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge aclk);
         c++;
      end while (tx_bit_tick !== 1'b1 && c < 1000);
      if (c >= 1000) hang;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      chk_bit(uart_irq, 1'b0, "irq after reset");
      rd_chk(`OFS_DIV_LOW, 32'h0, "divisor low");
      rd_chk(`OFS_DIV_HIGH, 32'h0, "divisor high");
      rd_chk(`OFS_BUF_CTRL, 32'h0, "buffer control");
      rd_chk(`OFS_FILL_CNT, 32'h0, "fill count");
      rd_chk(`OFS_STATUS, 32'h0, "status");
      axr(8'h1C, d, r);
      chk_word({30'h0, r}, {30'h0, `AXI_SLVERR}, "unmapped read");
      axw(`OFS_FILL_CNT, 32'h7, r);
      chk_word({30'h0, r}, {30'h0, `AXI_SLVERR}, "count write");
      rd_chk(`OFS_FILL_CNT, 32'h0, "count unchanged");
      wr(`OFS_BUF_CTRL, 32'hFF);
      rd_chk(`OFS_BUF_CTRL, 32'h3F, "top bits");
      $display("test reset done");
   endtask
   task automatic t_tx;
      int f, k, c;
      int len [8] = '{16, 17, 16, 16, 17, 16, 17, 16};
      setup(16'd16, 3'h3, 1'b0, 2'h1);
      wr(`OFS_UNIT_CTRL, 32'h1);
      for (f = 0; f < 2; f++) begin
         tx_frame_start <= 1'b1;
         @(posedge aclk);
         tx_frame_start <= 1'b0;
         wait_tick(c);
         for (k = 0; k < 8; k++) begin
            wait_tick(c);
            chk_word(32'(c), 32'(len[k]), "tx bit length");
         end
         wait_tick(c);
      end
      $display("test transmit timing done");
   endtask
   task automatic t_fill;
      int code, k, thr;
      logic ie;
      for (code = 0; code < 4; code++) begin
         thr = (code == 0) ? 4 : code;
         ie = code[0];
         wr(`OFS_UNIT_CTRL, 32'h0);
         wr(`OFS_BUF_CTRL, {26'h0, 3'h3, 1'b0, 2'(code)});
         wr(`OFS_UNIT_CTRL, {30'h0, ie, 1'b1});
         for (k = 1; k <= 4; k++) begin
            line.send(8'hA0 + 8'(k), 16'd16, 3'h3);
            rd_chk(`OFS_FILL_CNT, 32'(k), "fill count");
            rd_chk(`OFS_STATUS, {31'h0, k >= thr}, "data flag");
            chk_bit(uart_irq, ie && (k >= thr), "irq");
         end
      end
      line.send(8'hA5, 16'd16, 3'h3);
      line.send(8'hA6, 16'd16, 3'h3);
      rd_chk(`OFS_FILL_CNT, 32'h4, "count held at four");
      rd_chk(`OFS_STATUS, 32'h3, "overrun");
      for (k = 1; k <= 5; k++) begin
         rd_chk(`OFS_RX_DATA, (k == 5) ? 32'hA6 : 32'hA0 + 32'(k), "byte");
         rd_chk(`OFS_FILL_CNT, (k == 1) ? 32'h4 : 32'(5 - k), "pop");
      end
      rd_chk(`OFS_RX_DATA, 32'h0, "empty read");
      wr(`OFS_STATUS, 32'h2);
      rd_chk(`OFS_STATUS, 32'h0, "overrun cleared");
      $display("test fill and overrun done");
   endtask
   task automatic t_range;
      wr(`OFS_UNIT_CTRL, 32'h0);
      setup(16'd8, 3'h5, 1'b1, 2'h1);
      wr(`OFS_UNIT_CTRL, 32'h3);
      line.send(8'h3C, 16'd8, 3'h5);
      rd_chk(`OFS_STATUS, 32'h1, "flag at one byte");
      rd_chk(`OFS_RX_DATA, 32'h3C, "range one byte");
      line.send(8'h81, 16'd8, 3'h5);
      wr(`OFS_UNIT_CTRL, 32'h2);
      rd_chk(`OFS_FILL_CNT, 32'h0, "count after disable");
      rd_chk(`OFS_STATUS, 32'h0, "flags after disable");
      chk_bit(uart_irq, 1'b0, "irq after disable");
      rd_chk(`OFS_BUF_CTRL, 32'h2D, "control kept");
      rd_chk(`OFS_DIV_LOW, 32'h8, "divisor kept");
      $display("test range one and disable done");
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, tx_frame_start} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_tx;
      t_fill;
      t_range;
      final_report;
   end
endmodule // tb
